// [adc_trig_asserts.sv]
// ----
// Bus handshake and pulse checks
// ----
module adc_trig_asserts (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus.
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Converter side.
  input wire logic [20:0] conv_request,
  input wire logic single_request,
  input wire logic common_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence rd_offered;
    s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
  endsequence
  sequence resp_waiting;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  read_answer_a: assert property (rd_offered |=> s_axi_arready && s_axi_rvalid)
    else $error("Read not answered next cycle.");
  resp_hold_a: assert property (resp_waiting |=> s_axi_bvalid)
    else $error("Write response dropped early.");
  resp_cause_a: assert property ($rose(s_axi_bvalid) |->
    $past(s_axi_awready) || $past(s_axi_wready))
    else $error("Write response without a taken request.");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data changed while waiting.");
  bresp_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("Write response not okay.");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("Address ready held too long.");
  single_pulse_a: assert property (single_request |=> !single_request)
    else $error("Single request longer than one cycle.");
  irq_pulse_a: assert property (common_irq |=> !common_irq)
    else $error("Common interrupt longer than one cycle.");
  reset_quiet_a: assert property ($rose(aresetn) |-> conv_request == 21'h0 && !common_irq)
    else $error("Outputs busy after reset.");
endmodule : adc_trig_asserts

// [adc_trig_defines.svh]
`ifndef ADC_TRIG_DEFINES_SVH
`define ADC_TRIG_DEFINES_SVH
// Register byte offsets.
`define OFS_CTRL3_LO 6'h00
`define OFS_CTRL3_HI 6'h04
`define OFS_PWR_STAT 6'h08
`define OFS_WARM_IRQ 6'h0C
`define OFS_LVL_LO 6'h10
`define OFS_LVL_HI 6'h14
`define OFS_EIE_LO 6'h18
`define OFS_EIE_HI 6'h1C
`define OFS_EIS_LO 6'h20
`define OFS_EIS_HI 6'h24
`define OFS_TRGSRC 6'h28
`define OFS_CORE_DIV 6'h2C
// Field positions.
`define B_REF_SELECT 13
`define B_SUSPEND 12
`define B_SUSPIE 11
`define B_SUSPFLAG 10
`define B_DIRSAMP 9
`define B_CHTRIG 8
`define B_LVLTRIG 7
`define B_COMTRIG 6
`define B_CLKSRC 14
`define B_CLK_DIV 8
`define B_SHR_EN 7
`define B_READY 15
`define B_POWER 7
`define B_WARM 8
`define B_RDYIE 7
`define B_EARLY_MODE 12
// Codes and reset values.
`define REF_SELECT_SUPPLY 3'h0
`define TRG_NONE 5'h00
`define TRG_SW_COMMON 5'h01
`define TRG_SW_LEVEL 5'h02
`define WARM_MIN_CODE 4'h4
`define RST_ZERO 16'h0000
`endif

// [adc_trig_pkg.sv]
package adc_trig_pkg;
  typedef enum logic [1:0] {PW_OFF, PW_WARM, PW_READY} pwr_e;
  typedef logic [20:0] chan_t;
endpackage : adc_trig_pkg

// [adc_trigger_power_control.sv]
`include "adc_trig_defines.svh"
// Summary of operation
// - Reference select holds only code 000; other written codes are dropped.
// - Suspend set blocks every new trigger to all cores.
// - Suspended flag is 1 only while suspended and no conversion runs.
// - Suspend interrupt enable raises common interrupt when suspended flag sets.
// - Direct sampling bit holds shared core sampling the selected channel.
// - Single channel trigger fires once for selected channel, then self-clears.
// - Six-bit channel select names the channel of the single trigger.
// - Common software trigger fires once to common-source channels, then self-clears.
// - Level software trigger, while set, continuously triggers level-sensitive level-source channels; edge-sensitive ones fire once.
// - Two-bit clock source field selects the module clock source.
// - Common divider divides the module clock by value plus one.
// - The shared core divides the core source clock by its own divider.
// - Shared core enable turns shared core on or off.
// - Power bit powers shared core; ready reads 1 only when ready.
// - Warm-up code sets delay two to the code, minimum sixteen periods.
// - Ready interrupt enable raises common interrupt when core becomes ready.
// - Per-channel bit selects level or edge sensitive trigger input.
// - Per-channel enable allows or blocks that channel's early interrupt.
// - Early status sets when early interrupt occurs, clears on buffer read.
// - Trigger source code 1 common, 2 level software, 0 none.
// - Global early enable selects early or result-ready channel interrupts.
module adc_trigger_power_control
  import adc_trig_pkg::*;
#(
  parameter int NCH = 21,
  parameter int WARM_MAX = 32768
)(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write.
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter side.
  input wire logic core_clk_tick,
  input wire logic [20:0] hw_trigger_in,
  input wire logic [20:0] conv_busy,
  input wire logic [20:0] early_event,
  input wire logic [20:0] result_ready,
  input wire logic [20:0] result_buffer_read,
  output logic [20:0] conv_request,
  output logic [5:0] single_channel,
  output logic single_request,
  output logic direct_sampling,
  output logic shared_core_enable,
  output logic shared_core_powered,
  output logic [1:0] module_clock_source,
  output logic [5:0] common_clock_divider,
  output logic [6:0] shared_core_divider,
  output logic [20:0] channel_irq,
  output logic common_irq
);

  // Only the channel count and warm-up range that the register map holds are served.
  if (NCH != 21 || WARM_MAX != 32768)
  begin : g_bad_params
    $error("Unsupported parameter values.");
  end

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aw_got; logic [5:0] aw_a;
    logic w_got; logic [31:0] w_d; logic [3:0] w_s;
    logic awready; logic wready; logic bvalid;
    logic arready; logic rvalid; logic [31:0] rdata;
    logic suspend; logic susp_ie; logic susp_flag;
    logic dir_samp; logic ch_trig; logic lvl_trig; logic com_trig;
    logic [5:0] ch_sel; logic [1:0] clk_src; logic [5:0] clk_div;
    logic shr_en; logic power; logic [3:0] warm; logic rdy_ie; logic early_mode;
    logic [6:0] shr_div;
    chan_t lvl_en; chan_t eie; chan_t eis;
    logic [4:0] trg_src;
    chan_t trig_prev;
    pwr_e pstate; logic [15:0] wcnt; logic ready;
    chan_t req; logic [5:0] s_ch; logic s_req; chan_t chirq; logic cirq;
  } state_s;

  state_s q_q, d_q;

  // The load value is the number of core source ticks until the core is ready.
  function automatic logic [15:0] warm_count(input logic [3:0] code);
    if (code < `WARM_MIN_CODE)
      warm_count = 16'h0010;
    else
      warm_count = 16'(17'h00001 << code);
  endfunction : warm_count

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] stb);
    merge16 = old;
    if (stb[0])
      merge16[7:0] = dat[7:0];
    if (stb[1])
      merge16[15:8] = dat[15:8];
  endfunction : merge16

  logic [15:0] r3l, r3h, r5l, r5h, tmp;
  logic wr_go, rd_go, last_done;
  chan_t src_hit, tr_cur, fire;

  always_comb
  begin
    d_q = q_q;
    tmp = 16'h0000;
    r3l = {`REF_SELECT_SUPPLY, q_q.suspend, q_q.susp_ie, q_q.susp_flag, q_q.dir_samp,
           q_q.ch_trig, q_q.lvl_trig, q_q.com_trig, q_q.ch_sel};
    r3h = {q_q.clk_src, q_q.clk_div, q_q.shr_en, 7'h00};
    r5l = {q_q.ready, 7'h00, q_q.power, 7'h00};
    r5h = {3'h0, q_q.early_mode, q_q.warm, q_q.rdy_ie, 7'h00};
    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    d_q.awready = 1'b0;
    d_q.wready = 1'b0;
    d_q.arready = 1'b0;
    // Address and data are taken in either order and held until both are in.
    if (s_axi_awvalid && !q_q.aw_got && !q_q.awready && !q_q.bvalid)
    begin
      d_q.awready = 1'b1;
      d_q.aw_got = 1'b1;
      d_q.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q_q.w_got && !q_q.wready && !q_q.bvalid)
    begin
      d_q.wready = 1'b1;
      d_q.w_got = 1'b1;
      d_q.w_d = s_axi_wdata;
      d_q.w_s = s_axi_wstrb;
    end
    wr_go = q_q.aw_got && q_q.w_got && !q_q.bvalid;
    if (q_q.bvalid && s_axi_bready)
      d_q.bvalid = 1'b0;
    // Self-clearing triggers last exactly one cycle.
    d_q.ch_trig = 1'b0;
    d_q.com_trig = 1'b0;
    if (wr_go)
    begin
      d_q.aw_got = 1'b0;
      d_q.w_got = 1'b0;
      d_q.bvalid = 1'b1;
      case (q_q.aw_a)
        `OFS_CTRL3_LO:
        begin
          tmp = merge16(r3l, q_q.w_d, q_q.w_s);
          d_q.suspend = tmp[`B_SUSPEND];
          d_q.susp_ie = tmp[`B_SUSPIE];
          d_q.dir_samp = tmp[`B_DIRSAMP];
          d_q.ch_trig = tmp[`B_CHTRIG] && q_q.w_s[1];
          d_q.lvl_trig = tmp[`B_LVLTRIG];
          d_q.com_trig = tmp[`B_COMTRIG] && q_q.w_s[0];
          d_q.ch_sel = tmp[5:0];
        end
        `OFS_CTRL3_HI:
        begin
          tmp = merge16(r3h, q_q.w_d, q_q.w_s);
          d_q.clk_src = tmp[`B_CLKSRC +: 2];
          d_q.clk_div = tmp[`B_CLK_DIV +: 6];
          d_q.shr_en = tmp[`B_SHR_EN];
        end
        `OFS_PWR_STAT:
        begin
          tmp = merge16(r5l, q_q.w_d, q_q.w_s);
          d_q.power = tmp[`B_POWER];
        end
        `OFS_WARM_IRQ:
        begin
          tmp = merge16(r5h, q_q.w_d, q_q.w_s);
          d_q.warm = tmp[`B_WARM +: 4];
          d_q.rdy_ie = tmp[`B_RDYIE];
          d_q.early_mode = tmp[`B_EARLY_MODE];
        end
        `OFS_LVL_LO: d_q.lvl_en[15:0] = merge16(q_q.lvl_en[15:0], q_q.w_d, q_q.w_s);
        `OFS_LVL_HI: d_q.lvl_en[20:16] = q_q.w_s[0] ? q_q.w_d[4:0] : q_q.lvl_en[20:16];
        `OFS_EIE_LO: d_q.eie[15:0] = merge16(q_q.eie[15:0], q_q.w_d, q_q.w_s);
        `OFS_EIE_HI: d_q.eie[20:16] = q_q.w_s[0] ? q_q.w_d[4:0] : q_q.eie[20:16];
        `OFS_EIS_LO: d_q.eis[15:0] = merge16(q_q.eis[15:0], q_q.w_d, q_q.w_s);
        `OFS_EIS_HI: d_q.eis[20:16] = q_q.w_s[0] ? q_q.w_d[4:0] : q_q.eis[20:16];
        `OFS_TRGSRC: d_q.trg_src = q_q.w_s[0] ? q_q.w_d[4:0] : q_q.trg_src;
        `OFS_CORE_DIV: d_q.shr_div = q_q.w_s[0] ? q_q.w_d[6:0] : q_q.shr_div;
        default: tmp = 16'h0000;
      endcase
    end
    // Reference select is not stored: it always reads the supply code.
    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    rd_go = s_axi_arvalid && !q_q.arready && !q_q.rvalid;
    if (q_q.rvalid && s_axi_rready)
      d_q.rvalid = 1'b0;
    if (rd_go)
    begin
      d_q.arready = 1'b1;
      d_q.rvalid = 1'b1;
      case (s_axi_araddr)
        `OFS_CTRL3_LO: d_q.rdata = {16'h0000, r3l};
        `OFS_CTRL3_HI: d_q.rdata = {16'h0000, r3h};
        `OFS_PWR_STAT: d_q.rdata = {16'h0000, r5l};
        `OFS_WARM_IRQ: d_q.rdata = {16'h0000, r5h};
        `OFS_LVL_LO: d_q.rdata = {16'h0000, q_q.lvl_en[15:0]};
        `OFS_LVL_HI: d_q.rdata = {27'h0000000, q_q.lvl_en[20:16]};
        `OFS_EIE_LO: d_q.rdata = {16'h0000, q_q.eie[15:0]};
        `OFS_EIE_HI: d_q.rdata = {27'h0000000, q_q.eie[20:16]};
        `OFS_EIS_LO: d_q.rdata = {16'h0000, q_q.eis[15:0]};
        `OFS_EIS_HI: d_q.rdata = {27'h0000000, q_q.eis[20:16]};
        `OFS_TRGSRC: d_q.rdata = {27'h0000000, q_q.trg_src};
        `OFS_CORE_DIV: d_q.rdata = {25'h0000000, q_q.shr_div};
        default: d_q.rdata = 32'h00000000;
      endcase
    end
    // ----------------------------------------------------------------
    // Triggers
    // ----------------------------------------------------------------
    // All channels share one source selection; there is no per-channel source map.
    src_hit = '0;
    case (q_q.trg_src)
      `TRG_SW_COMMON: src_hit = {NCH{q_q.com_trig}};
      `TRG_SW_LEVEL: src_hit = {NCH{q_q.lvl_trig}};
      `TRG_NONE: src_hit = '0;
      default: src_hit = '0;
    endcase
    tr_cur = hw_trigger_in | src_hit;
    // History resets low, the idle level of a trigger, so no false edge follows reset.
    d_q.trig_prev = tr_cur;
    fire = (q_q.lvl_en & tr_cur) | (~q_q.lvl_en & tr_cur & ~q_q.trig_prev);
    d_q.req = q_q.suspend ? '0 : fire;
    d_q.s_req = q_q.ch_trig && !q_q.suspend;
    d_q.s_ch = q_q.ch_sel;
    // ----------------------------------------------------------------
    // Suspend and early status
    // ----------------------------------------------------------------
    d_q.susp_flag = q_q.suspend && (conv_busy == '0);
    // A hardware set wins over a buffer-read clear in the same cycle.
    for (int i = 0; i < NCH; i++)
    begin
      if (result_buffer_read[i])
        d_q.eis[i] = 1'b0;
      if (early_event[i] && q_q.eie[i])
        d_q.eis[i] = 1'b1;
    end
    d_q.chirq = q_q.early_mode ? (early_event & q_q.eie) : result_ready;
    // ----------------------------------------------------------------
    // Shared core power-up
    // ----------------------------------------------------------------
    last_done = 1'b0;
    case (q_q.pstate)
      PW_OFF:
      begin
        d_q.ready = 1'b0;
        if (q_q.power)
        begin
          d_q.pstate = PW_WARM;
          d_q.wcnt = warm_count(q_q.warm);
        end
      end
      PW_WARM:
      begin
        if (!q_q.power)
          d_q.pstate = PW_OFF;
        else if (core_clk_tick)
        begin
          if (q_q.wcnt == 16'h0001)
          begin
            d_q.pstate = PW_READY;
            d_q.ready = 1'b1;
            last_done = 1'b1;
          end
          else
            d_q.wcnt = q_q.wcnt - 16'h0001;
        end
      end
      PW_READY:
      begin
        if (!q_q.power)
        begin
          d_q.pstate = PW_OFF;
          d_q.ready = 1'b0;
        end
      end
      default: d_q.pstate = PW_OFF;
    endcase
    d_q.cirq = (q_q.susp_ie && q_q.suspend && d_q.susp_flag && !q_q.susp_flag)
            || (q_q.rdy_ie && last_done);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_q <= '0;
    end
    else
    begin
      q_q <= d_q;
    end
  end

  assign s_axi_awready = q_q.awready;
  assign s_axi_wready = q_q.wready;
  assign s_axi_bresp = 2'h0;
  assign s_axi_bvalid = q_q.bvalid;
  assign s_axi_arready = q_q.arready;
  assign s_axi_rdata = q_q.rdata;
  assign s_axi_rresp = 2'h0;
  assign s_axi_rvalid = q_q.rvalid;
  assign conv_request = q_q.req;
  assign single_channel = q_q.s_ch;
  assign single_request = q_q.s_req;
  assign direct_sampling = q_q.dir_samp;
  assign shared_core_enable = q_q.shr_en;
  assign shared_core_powered = q_q.power;
  assign module_clock_source = q_q.clk_src;
  assign common_clock_divider = q_q.clk_div;
  assign shared_core_divider = q_q.shr_div;
  assign channel_irq = q_q.chirq;
  assign common_irq = q_q.cirq;

endmodule : adc_trigger_power_control

// [adc_trigger_power_control_tb.sv]
`include "adc_trig_defines.svh"
module adc_trigger_power_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0;
  logic aresetn = 0;
  logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, core_clk_tick = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, v, sr_cnt = '0, req_cnt = '0, irq_cnt = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [20:0] hw_trigger_in = '0, conv_busy = '0, early_event = '0, result_ready = '0;
  logic [20:0] result_buffer_read = '0, conv_request, channel_irq, req_or = '0, ch_or = '0;
  logic s_axi_arready, s_axi_rvalid, single_request, direct_sampling, shared_core_enable;
  logic shared_core_powered, common_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, module_clock_source;
  logic [5:0] single_channel, common_clock_divider, sr_ch;
  logic [6:0] shared_core_divider;
  int fail_count = 0, cmp_count = 0, k, t;
  adc_trigger_power_control dut_u (.*);
  always #25 aclk = ~aclk;
  // Pulses are collected here so that no check depends on the exact cycle a pulse lands.
  always @(posedge aclk)
  begin
    if (aresetn)
    begin
      sr_cnt += single_request;
      req_cnt += conv_request[3];
      irq_cnt += common_irq;
      req_or |= conv_request;
      ch_or |= channel_irq;
      if (single_request === 1'h1)
        sr_ch = single_channel;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic cyc(input int c);
    repeat (c) @(posedge aclk);
  endtask : cyc
  task automatic give_up(input int n);
    if (n >= 60)
    begin
      fail_count++;
      close_out();
    end
  endtask : give_up
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int n;
    bit ad;
    bit wd;
    n = 0;
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(ad && wd) && n < 60)
    begin
      @(posedge aclk);
      n++;
      ad |= s_axi_awready;
      wd |= s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (s_axi_bvalid !== 1'h1 && n < 60);
    s_axi_bready <= 1'h0;
    give_up(n);
  endtask : wr
  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    int n;
    bit ad;
    n = 0;
    ad = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      ad |= s_axi_arready;
      s_axi_arvalid <= !ad;
      v = s_axi_rdata;
    end
    while (s_axi_rvalid !== 1'h1 && n < 60);
    chk(s_axi_rresp, 2'h0);
    s_axi_rready <= 1'h0;
    @(posedge aclk);
    give_up(n);
    chk(v, e);
  endtask : rc
  initial
  begin
    cyc(10);
    aresetn <= 1'h1;
    for (k = 0; k < 13; k++)
      rc(6'(k * 4), 32'h0);
    wr(`OFS_CTRL3_LO, 32'hE000);
    rc(`OFS_CTRL3_LO, 32'h0);
    wr(6'h30, '1);
    rc(6'h30, 32'h0);
    for (k = 0; k < 6; k++)
    begin
      wr(`OFS_LVL_LO + 6'(k * 4), '1);
      rc(`OFS_LVL_LO + 6'(k * 4), k[0] ? 32'h1F : 32'hFFFF);
      wr(`OFS_LVL_LO + 6'(k * 4), '0);
    end
    for (k = 0; k < 4; k++)
    begin
      wr(`OFS_CTRL3_HI, (32'(k) << 14) | 32'h2A80);
      chk(module_clock_source, k[1:0]);
      chk(common_clock_divider, 6'h2A);
      chk(shared_core_enable, 1'h1);
    end
    wr(`OFS_CORE_DIV, 32'h55);
    chk(shared_core_divider, 7'h55);
    wr(`OFS_CTRL3_LO, 32'h200);
    chk(direct_sampling, 1'h1);
    wr(`OFS_CTRL3_LO, 32'h0);
    chk(direct_sampling, 1'h0);
    wr(`OFS_CTRL3_LO, 32'h10D);
    cyc(6);
    chk(sr_cnt, 32'h1);
    chk(sr_ch, 6'hD);
    rc(`OFS_CTRL3_LO, 32'hD);
    conv_busy <= '1;
    wr(`OFS_CTRL3_LO, 32'h190D);
    cyc(6);
    chk(sr_cnt, 32'h1);
    rc(`OFS_CTRL3_LO, 32'h180D);
    conv_busy <= '0;
    cyc(5);
    chk(common_irq, 1'h0);
    chk(irq_cnt, 32'h1);
    rc(`OFS_CTRL3_LO, 32'h1C0D);
    wr(`OFS_CTRL3_LO, 32'h0);
    wr(`OFS_TRGSRC, 32'h1);
    req_or = '0;
    req_cnt = '0;
    wr(`OFS_CTRL3_LO, 32'h40);
    cyc(5);
    chk(req_or, 21'h1FFFFF);
    chk(req_cnt, 32'h1);
    rc(`OFS_CTRL3_LO, 32'h0);
    wr(`OFS_LVL_LO, 32'hFFFF);
    wr(`OFS_LVL_HI, 32'h1F);
    wr(`OFS_TRGSRC, 32'h2);
    wr(`OFS_CTRL3_LO, 32'h80);
    cyc(4);
    chk(conv_request, 21'h1FFFFF);
    cyc(3);
    chk(conv_request, 21'h1FFFFF);
    wr(`OFS_CTRL3_LO, 32'h0);
    cyc(3);
    chk(conv_request, 21'h0);
    wr(`OFS_LVL_LO, 32'h0);
    wr(`OFS_LVL_HI, 32'h0);
    wr(`OFS_TRGSRC, 32'h0);
    req_cnt = '0;
    hw_trigger_in <= 21'h8;
    cyc(8);
    hw_trigger_in <= '0;
    cyc(3);
    chk(req_cnt, 32'h1);
    for (k = 0; k < 2; k++)
    begin
      wr(`OFS_PWR_STAT, 32'h0);
      wr(`OFS_WARM_IRQ, 32'(k) * 32'h400 | 32'h80);
      wr(`OFS_PWR_STAT, 32'h80);
      v = '0;
      t = 0;
      while (common_irq !== 1'h1 && t < 400)
      begin
        @(posedge aclk);
        t++;
        v += core_clk_tick;
        core_clk_tick <= (t % 4 == 0);
      end
      if (t >= 400)
        give_up(60);
      chk(v, 32'h10);
      chk(common_irq, 1'h1);
      chk(shared_core_powered, 1'h1);
      @(posedge aclk);
      core_clk_tick <= 1'h0;
      rc(`OFS_PWR_STAT, 32'h8080);
    end
    wr(`OFS_PWR_STAT, 32'h0);
    rc(`OFS_PWR_STAT, 32'h0);
    wr(`OFS_WARM_IRQ, 32'h1000);
    wr(`OFS_EIE_LO, 32'h4);
    ch_or = '0;
    early_event <= 21'h24;
    @(posedge aclk);
    early_event <= '0;
    cyc(3);
    chk(ch_or, 21'h4);
    rc(`OFS_EIS_LO, 32'h4);
    result_buffer_read <= 21'h4;
    @(posedge aclk);
    result_buffer_read <= '0;
    rc(`OFS_EIS_LO, 32'h0);
    wr(`OFS_WARM_IRQ, 32'h0);
    ch_or = '0;
    result_ready <= 21'h80;
    cyc(3);
    chk(ch_or, 21'h80);
    close_out();
  end
endmodule : adc_trigger_power_control_tb
bind adc_trigger_power_control adc_trig_asserts chk_u (.*);
